// >>> hw/tmrcc_pkg.sv
// Package for the timer channel with input capture: register map, fields, codes.
// Assumes a 32-bit APB slave with one aligned word per register.
package tmrcc_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_RELOAD = 8'h08;
    localparam logic [7:0] OFF_CAPTURE = 8'h0C;
    localparam logic [7:0] OFF_START = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTRL_CAP_FLAG = 9;
    localparam int CTRL_UNF_FLAG = 8;
    localparam int CTRL_CAP_HI = 7;
    localparam int CTRL_CAP_LO = 6;
    localparam int CTRL_UNF_IE = 5;
    localparam int CTRL_EDGE_HI = 4;
    localparam int CTRL_EDGE_LO = 3;
    localparam int CTRL_CLK_HI = 2;
    localparam int CTRL_CLK_LO = 0;
    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status bits
    localparam int IRQ_UNF = 0;
    localparam int IRQ_CAP = 1;
    localparam int IRQ_BITS = 2;
    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] COUNT_RST = 32'hFFFFFFFF;
    localparam logic [31:0] RELOAD_RST = 32'hFFFFFFFF;
    localparam logic [31:0] CAPTURE_RST = 32'h00000000;
    ////////////////////////////////////////////////////////////////////////////
    // Codes
    localparam logic [1:0] CAP_OFF = 2'h0;
    localparam logic [1:0] CAP_IRQ = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [2:0] CLK_DIV4 = 3'h0;
    localparam logic [2:0] CLK_DIV16 = 3'h1;
    localparam logic [2:0] CLK_DIV64 = 3'h2;
    localparam logic [2:0] CLK_DIV256 = 3'h3;
    localparam logic [2:0] CLK_RTC = 3'h4;
    localparam logic [2:0] CLK_PIN = 3'h5;
    localparam int PRESC_WIDTH = 8;
endpackage

// >>> hw/tmrcc_edge_detect.sv
// Two-flop synchroniser and selectable edge detector for an asynchronous pin.
// Assumes an active-low reset, asserted asynchronously and released synchronously by the top module.
`timescale 1ns/100ps
module tmrcc_edge_detect (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Pin and edge choice
    input wire logic pin_in,
    input wire logic [1:0] edge_sel_in,
    // One-cycle edge pulse
    output logic edge_out
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    wire rise = sync_q & ~prev_q;
    wire fall = ~sync_q & prev_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Upper bit picks both edges, else low bit picks falling
    assign edge_out = edge_sel_in[1] ? (rise | fall) :
                      (edge_sel_in[0] ? fall : rise);
endmodule

// >>> hw/tmrcc_prescaler.sv
// Free-running prescaler and count-clock selector for the down counter.
// Assumes rtc and pin ticks are already synchronous one-cycle pulses.
`timescale 1ns/100ps
module tmrcc_prescaler #(
    parameter int WIDTH = tmrcc_pkg::PRESC_WIDTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Source choice and alternate ticks
    input wire logic [2:0] clock_sel_in,
    input wire logic rtc_tick_in,
    input wire logic pin_tick_in,
    // Selected count tick
    output logic tick_out
);
    logic [WIDTH-1:0] div_q;
    logic [3:0] tap;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Taps divide by 4, 16, 64 and 256
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_tap
            assign tap[i] = &div_q[2*i+1:0];
        end
    endgenerate

    // Source decode; codes 11x give no tick
    assign tick_out = (clock_sel_in == tmrcc_pkg::CLK_DIV4) ? tap[0] :
                      (clock_sel_in == tmrcc_pkg::CLK_DIV16) ? tap[1] :
                      (clock_sel_in == tmrcc_pkg::CLK_DIV64) ? tap[2] :
                      (clock_sel_in == tmrcc_pkg::CLK_DIV256) ? tap[3] :
                      (clock_sel_in == tmrcc_pkg::CLK_RTC) ? rtc_tick_in :
                      (clock_sel_in == tmrcc_pkg::CLK_PIN) ? pin_tick_in : 1'b0;
endmodule

// >>> hw/tmrcc_top.sv
// Timer channel with input capture: APB registers, down counter, flags, interrupts.
// Assumes mclk_in at 50 MHz; timer and rtc pins are asynchronous.
`timescale 1ns/100ps
module tmrcc_top (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // External pins
    input wire logic timer_pin_in,
    input wire logic rtc_clock_out_in,
    // Interrupts
    output logic underflow_interrupt_out,
    output logic capture_interrupt_out,
    output logic irq_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_q;
    logic rst_sync_q;
    wire rst_n = rst_sync_q;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [1:0] cap_ctrl_q;
    logic unf_ie_q;
    logic [1:0] edge_sel_q;
    logic [2:0] clock_sel_q;
    logic capture_flag_q;
    logic underflow_flag_q;
    logic start_q;
    logic [31:0] count_q;
    logic [31:0] reload_q;
    logic [31:0] capture_q;
    logic [tmrcc_pkg::IRQ_BITS-1:0] irq_stat_q;
    logic [tmrcc_pkg::IRQ_BITS-1:0] irq_mask_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic unf_irq_q;
    logic cap_irq_q;
    logic irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection and count clock
    logic pin_edge;
    logic rtc_edge;
    logic tick;

    // One edge choice serves counting and capture
    tmrcc_edge_detect u_pin_edge (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .pin_in(timer_pin_in),
        .edge_sel_in(edge_sel_q),
        .edge_out(pin_edge)
    );

    tmrcc_edge_detect u_rtc_edge (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .pin_in(rtc_clock_out_in),
        .edge_sel_in(tmrcc_pkg::EDGE_RISE),
        .edge_out(rtc_edge)
    );

    tmrcc_prescaler u_presc (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .clock_sel_in(clock_sel_q),
        .rtc_tick_in(rtc_edge),
        .pin_tick_in(pin_edge),
        .tick_out(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire access = psel_in & penable_in;
    wire commit = access & pready_q;
    wire wr = commit & pwrite_in;
    wire hit_ctrl = (paddr_in == tmrcc_pkg::OFF_CTRL);
    wire hit_count = (paddr_in == tmrcc_pkg::OFF_COUNT);
    wire hit_reload = (paddr_in == tmrcc_pkg::OFF_RELOAD);
    wire hit_capture = (paddr_in == tmrcc_pkg::OFF_CAPTURE);
    wire hit_start = (paddr_in == tmrcc_pkg::OFF_START);
    wire hit_stat = (paddr_in == tmrcc_pkg::OFF_IRQ_STAT);
    wire hit_mask = (paddr_in == tmrcc_pkg::OFF_IRQ_MASK);
    wire mapped = hit_ctrl | hit_count | hit_reload | hit_capture | hit_start |
                  hit_stat | hit_mask;
    wire wr_ctrl = wr & hit_ctrl;
    wire wr_count = wr & hit_count;
    wire wr_stat = wr & hit_stat;

    // Bits 15 to 10 are held at zero on readback
    wire [31:0] ctrl_rd = {22'h000000, capture_flag_q, underflow_flag_q, cap_ctrl_q,
                           unf_ie_q, edge_sel_q, clock_sel_q};
    wire [31:0] rdata = hit_ctrl ? ctrl_rd :
                        hit_count ? count_q :
                        hit_reload ? reload_q :
                        hit_capture ? capture_q :
                        hit_start ? {31'h00000000, start_q} :
                        hit_stat ? {30'h00000000, irq_stat_q} :
                        hit_mask ? {30'h00000000, irq_mask_q} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Events
    wire cap_en = cap_ctrl_q[1];
    wire cap_hit = cap_en & pin_edge;
    wire step = start_q & tick;
    wire unf_hit = step & (count_q == 32'h00000000);
    wire [tmrcc_pkg::IRQ_BITS-1:0] events = {cap_hit, unf_hit};

    // Set wins over a same-cycle zero-write
    wire capture_flag_d = cap_hit | (capture_flag_q &
                          ~(wr_ctrl & ~pwdata_in[tmrcc_pkg::CTRL_CAP_FLAG]));
    wire underflow_flag_d = unf_hit | (underflow_flag_q &
                            ~(wr_ctrl & ~pwdata_in[tmrcc_pkg::CTRL_UNF_FLAG]));
    wire [tmrcc_pkg::IRQ_BITS-1:0] irq_stat_d = events |
                                   (irq_stat_q & ~({2{wr_stat}} & pwdata_in[1:0]));

    // Reload on underflow, else count down
    wire [31:0] count_d = wr_count ? pwdata_in :
                          unf_hit ? reload_q :
                          step ? count_q - 32'h00000001 : count_q;

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, commit when pready is high
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            prdata_q <= (access & ~pready_q & ~pwrite_in) ? rdata : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            cap_ctrl_q <= tmrcc_pkg::CAP_OFF;
            unf_ie_q <= 1'b0;
            edge_sel_q <= tmrcc_pkg::EDGE_RISE;
            clock_sel_q <= tmrcc_pkg::CLK_DIV4;
            capture_flag_q <= 1'b0;
            underflow_flag_q <= 1'b0;
        end else begin
            capture_flag_q <= capture_flag_d;
            underflow_flag_q <= underflow_flag_d;
            if (wr_ctrl) begin
                cap_ctrl_q <= pwdata_in[tmrcc_pkg::CTRL_CAP_HI:tmrcc_pkg::CTRL_CAP_LO];
                unf_ie_q <= pwdata_in[tmrcc_pkg::CTRL_UNF_IE];
                edge_sel_q <= pwdata_in[tmrcc_pkg::CTRL_EDGE_HI:tmrcc_pkg::CTRL_EDGE_LO];
                clock_sel_q <= pwdata_in[tmrcc_pkg::CTRL_CLK_HI:tmrcc_pkg::CTRL_CLK_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter, reload, capture, start
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= tmrcc_pkg::COUNT_RST;
            reload_q <= tmrcc_pkg::RELOAD_RST;
            capture_q <= tmrcc_pkg::CAPTURE_RST;
            start_q <= 1'b0;
        end else begin
            count_q <= count_d;
            if (wr & hit_reload) begin
                reload_q <= pwdata_in;
            end
            if (wr & hit_start) begin
                start_q <= pwdata_in[0];
            end
            if (cap_hit) begin
                capture_q <= count_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            unf_irq_q <= 1'b0;
            cap_irq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr & hit_mask) begin
                irq_mask_q <= pwdata_in[1:0];
            end
            unf_irq_q <= unf_ie_q & underflow_flag_q;
            cap_irq_q <= (cap_ctrl_q == tmrcc_pkg::CAP_IRQ) & capture_flag_q;
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign underflow_interrupt_out = unf_irq_q;
    assign capture_interrupt_out = cap_irq_q;
    assign irq_out = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n);

    sequence ctrl_zero_write_s(int bitpos);
        wr_ctrl && !pwdata_in[bitpos];
    endsequence

    sequence ctrl_read_s;
        access && !pready_q && !pwrite_in && hit_ctrl;
    endsequence

    rsvd_read_zero_a: assert property (ctrl_read_s |=> prdata_q[15:10] == 6'h00)
        else $error("reserved control bits read nonzero");
    cap_flag_set_a: assert property (cap_hit |=> capture_flag_q && capture_q == $past(count_q))
        else $error("capture did not set flag and copy counter");
    cap_flag_clr_a: assert property (ctrl_zero_write_s(9) and !cap_hit |=> !capture_flag_q)
        else $error("capture flag not cleared by zero write");
    unf_set_a: assert property (unf_hit && !wr_count |=> underflow_flag_q && count_q == $past(reload_q))
        else $error("underflow did not set flag and reload");
    unf_keep_a: assert property (underflow_flag_q && wr_ctrl && pwdata_in[8] |=> underflow_flag_q)
        else $error("writing one changed underflow flag");
    cap_irq_gate_a: assert property (capture_interrupt_out |-> $past(cap_ctrl_q) == 2'h3)
        else $error("capture interrupt without enable");
    unf_irq_a: assert property (unf_ie_q && underflow_flag_q |=> underflow_interrupt_out)
        else $error("underflow interrupt missing");
    pin_count_a: assert property (start_q && clock_sel_q == 3'h5 && pin_edge && count_q != 0
                                  && !wr_count |=> count_q == $past(count_q) - 1)
        else $error("pin edge did not decrement counter");
    set_wins_a: assert property (unf_hit and ctrl_zero_write_s(8) |=> underflow_flag_q)
        else $error("clear beat a same-cycle underflow");
    irq_out_a: assert property (|(irq_stat_q & irq_mask_q) |=> irq_out)
        else $error("masked status did not raise irq");
    reserved_clk_a: assert property (clock_sel_q[2:1] == 2'h3 && !wr_count |=> $stable(count_q))
        else $error("reserved clock code counted");
    cap_keep_a: assert property (capture_flag_q && wr_ctrl && pwdata_in[9]
                                 |=> capture_flag_q)
        else $error("writing one changed capture flag");
    unf_clr_a: assert property (ctrl_zero_write_s(8) and !unf_hit |=> !underflow_flag_q)
        else $error("underflow flag not cleared by zero write");
    unf_no_set_a: assert property (!unf_hit && !underflow_flag_q |=> !underflow_flag_q)
        else $error("underflow flag set without underflow");
    cap_no_set_a: assert property (!cap_hit && !capture_flag_q |=> !capture_flag_q)
        else $error("capture flag set without capture");
    cap_off_a: assert property (cap_ctrl_q == tmrcc_pkg::CAP_OFF |=> $stable(capture_q))
        else $error("capture register loaded while capture off");
    cap_irq_a: assert property (cap_ctrl_q == 2'h3 && capture_flag_q
                                |=> capture_interrupt_out)
        else $error("capture interrupt missing");
    unf_irq_gate_a: assert property (underflow_interrupt_out
                                     |-> $past(unf_ie_q) && $past(underflow_flag_q))
        else $error("underflow interrupt without enable and flag");
    irq_gate_a: assert property (irq_out |-> |($past(irq_stat_q) & $past(irq_mask_q)))
        else $error("irq without masked status");
    reset_vals_a: assert property ($rose(rst_n) |-> ctrl_rd == 32'h00000000
                                   && count_q == tmrcc_pkg::COUNT_RST)
        else $error("control or counter not at reset value");
endmodule

// >>> verification/tmrcc_pin_model.sv
// Far-side model: timer pin source and a free-running rtc clock.
// Assumes the bench moves the pin only through set_pin.
`timescale 1ns/100ps
module tmrcc_pin_model (
    // Clock
    input wire logic clk_in,
    // Pins towards the timer
    output logic timer_pin_out,
    output logic rtc_out
);
    int rtc_cnt = 0;
    initial begin
        timer_pin_out = 1'b0;
        rtc_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Rtc clock toggles every 10 cycles and never stops
    always @(posedge clk_in) begin
        rtc_cnt <= (rtc_cnt == 9) ? 0 : rtc_cnt + 1;
        if (rtc_cnt == 9) begin
            rtc_out <= ~rtc_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Pin only driven towards the timer; each level held 4 cycles
    task automatic set_pin(input logic v);
        @(posedge clk_in);
        timer_pin_out <= v;
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// >>> verification/tmrcc_top_bench.sv
// Self-checking bench for the timer channel with input capture.
// Assumes APB with one wait state and the pin model on the far side.
`timescale 1ns/100ps
module tmrcc_top_bench;
    localparam logic [7:0] A_CTL = tmrcc_pkg::OFF_CTRL;
    localparam logic [7:0] A_CNT = tmrcc_pkg::OFF_COUNT;
    localparam logic [7:0] A_REL = tmrcc_pkg::OFF_RELOAD;
    localparam logic [7:0] A_CAP = tmrcc_pkg::OFF_CAPTURE;
    localparam logic [7:0] A_RUN = tmrcc_pkg::OFF_START;
    localparam logic [7:0] A_STA = tmrcc_pkg::OFF_IRQ_STAT;
    localparam logic [7:0] A_MSK = tmrcc_pkg::OFF_IRQ_MASK;
    logic mclk_in;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready, pslverr, pin, rtc, unf_irq, cap_irq, irq, err;
    logic [31:0] rd;
    int fails = 0;
    int cmp_count = 0;
    tmrcc_top uut (.mclk_in(mclk_in), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .timer_pin_in(pin),
        .rtc_clock_out_in(rtc), .underflow_interrupt_out(unf_irq),
        .capture_interrupt_out(cap_irq), .irq_out(irq));
    tmrcc_pin_model pm (.clk_in(mclk_in), .timer_pin_out(pin), .rtc_out(rtc));
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            chk("pready", 1, 0);
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic settle();
        repeat (2) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask
    task automatic poll(input logic [7:0] a, input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 100);
        if (n == 100) begin
            chk("poll", 1, 0);
            finish_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        rdchk("ctrl reset", A_CTL, 32'h0);
        rdchk("count reset", A_CNT, 32'hFFFFFFFF);
    endtask
    task automatic t_reserved();
        wr(A_CTL, 32'h0000FFFF);
        rdchk("ctrl reserved", A_CTL, 32'h000000FF);
        wr(A_CTL, 32'h0);
    endtask
    task automatic t_underflow();
        wr(A_REL, 32'h5);
        wr(A_CNT, 32'h2);
        wr(A_CTL, 32'h20);
        wr(A_RUN, 32'h1);
        poll(A_CTL, 8);
        wr(A_RUN, 32'h0);
        apb(1'b0, A_CNT, 32'h0);
        chk("reloaded count", 1, 32'(rd <= 32'h5));
        settle();
        chk("unf irq", 1, unf_irq);
        chk("irq masked", 0, irq);
        wr(A_MSK, 32'h1);
        settle();
        chk("irq unmasked", 1, irq);
        wr(A_STA, 32'h1);
        settle();
        chk("irq cleared", 0, irq);
        wr(A_CTL, 32'h120);
        rdchk("unf kept", A_CTL, 32'h120);
        wr(A_CTL, 32'h20);
        rdchk("unf cleared", A_CTL, 32'h20);
        settle();
        chk("unf irq off", 0, unf_irq);
    endtask
    task automatic t_capture();
        wr(A_CNT, 32'h1234);
        wr(A_CTL, 32'hC0);
        pm.set_pin(1'b1);
        settle();
        rdchk("cap flag", A_CTL, 32'h2C0);
        rdchk("cap event", A_STA, 32'h2);
        chk("cap irq", 1, cap_irq);
        rdchk("capture", A_CAP, 32'h1234);
        wr(A_CTL, 32'hC0);
        rdchk("cap cleared", A_CTL, 32'hC0);
        pm.set_pin(1'b0);
        rdchk("no cap on fall", A_CTL, 32'hC0);
        wr(A_CNT, 32'h55);
        wr(A_CTL, 32'h88);
        pm.set_pin(1'b1);
        rdchk("no cap on rise", A_CTL, 32'h88);
        pm.set_pin(1'b0);
        settle();
        rdchk("cap on fall", A_CTL, 32'h288);
        chk("cap irq off", 0, cap_irq);
        rdchk("capture fall", A_CAP, 32'h55);
        wr(A_CTL, 32'h0);
        pm.set_pin(1'b1);
        pm.set_pin(1'b0);
        rdchk("cap disabled", A_CTL, 32'h0);
        rdchk("capture kept", A_CAP, 32'h55);
    endtask
    task automatic t_pin_count();
        for (int e = 0; e < 4; e++) begin
            wr(A_CNT, 32'd100);
            wr(A_CTL, 32'({e[1:0], tmrcc_pkg::CLK_PIN}));
            wr(A_RUN, 32'h1);
            pm.set_pin(1'b1);
            pm.set_pin(1'b0);
            settle();
            rdchk("pin count", A_CNT, e[1] ? 32'd98 : 32'd99);
        end
    endtask
    task automatic t_presc();
        logic [2:0] code[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
        int expv[7] = '{256, 64, 16, 4, 51, 0, 0};
        logic [31:0] d;
        for (int i = 0; i < 7; i++) begin
            wr(A_CTL, 32'(code[i]));
            wr(A_CNT, 32'h10000);
            repeat (1024) @(posedge mclk_in);
            apb(1'b0, A_CNT, 32'h0);
            d = 32'h10000 - rd;
            chk("ticks", 1, 32'(d + 2 >= expv[i] && d <= expv[i] + 2));
        end
        wr(A_RUN, 32'h0);
    endtask
    task automatic t_unmapped();
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped data", 0, rd);
        chk("unmapped err", 1, 32'(err));
        wr(A_CAP, 32'h99);
        rdchk("capture read only", A_CAP, 32'h55);
    endtask
    task automatic t_set_wins();
        wr(A_REL, 32'h0);
        wr(A_CNT, 32'h0);
        wr(A_RUN, 32'h1);
        // Underflow every tick; zero-writes slide across all tick phases
        for (int i = 0; i < 4; i++) begin
            wr(A_CTL, 32'h0);
            repeat (i + 1) @(posedge mclk_in);
        end
        wr(A_RUN, 32'h0);
        rdchk("unf after race", A_CTL, 32'h100);
        wr(A_CTL, 32'h0);
        wr(A_STA, 32'h3);
        rdchk("status cleared", A_STA, 32'h0);
    endtask
    task automatic t_midreset();
        wr(A_CTL, 32'h3D);
        wr(A_REL, 32'h7);
        @(posedge mclk_in);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk("pready in reset", 0, pready);
        chk("prdata in reset", 0, prdata);
        chk("unf irq in reset", 0, unf_irq);
        chk("irq in reset", 0, irq);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rdchk("ctrl after reset", A_CTL, 32'h0);
        rdchk("reload after reset", A_REL, 32'hFFFFFFFF);
        rdchk("count after reset", A_CNT, 32'hFFFFFFFF);
        rdchk("capture after reset", A_CAP, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h00000000;
        repeat (3) @(posedge mclk_in);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk_in);
        t_reset();
        t_reserved();
        t_underflow();
        t_set_wins();
        t_capture();
        t_pin_count();
        t_presc();
        t_unmapped();
        t_midreset();
        finish_test();
    end
endmodule
